// *** design/timer_wdog_regs.vh ***
// Register offsets, field positions, keys and reset values of the timer block
`ifndef TIMER_WDOG_REGS_VH
`define TIMER_WDOG_REGS_VH

`define ADDR_WD_PRESCALE_LOCK  4'h0
`define ADDR_WD_PRESCALE_START 4'h1
`define ADDR_TIMER_CONTROL     4'h2
`define ADDR_TIMER_PERIOD_LOW  4'h3
`define ADDR_TIMER_PERIOD_HIGH 4'h4
`define ADDR_TIMER_COUNT_LOW   4'h5
`define ADDR_TIMER_COUNT_HIGH  4'h6
`define ADDR_IRQ_STATUS        4'h7
`define ADDR_IRQ_MASK          4'h8
`define ADDR_WD_CONTROL        4'h9
`define ADDR_WD_COUNT          4'ha

`define PRESCALE_KEY1          16'h5a5a
`define PRESCALE_KEY2          16'ha5a5

`define LOCK_IDLE              2'h0
`define LOCK_WAIT_KEY2         2'h1
`define LOCK_OPEN              2'h3

`define TCR_ENABLE_BIT         15
`define TCR_DIV_MSB            5
`define TCR_DIV_LSB            2
`define TCR_RELOAD_BIT         1
`define TCR_START_BIT          0
`define TCR_WRITE_MASK         16'h803f
`define DIV_CODE_MAX           4'hc

`define IRQ_TIMER_BIT          0
`define IRQ_WDOG_BIT           1
`define IRQ_WIDTH              2

`define WD_RESET_PULSE_CYCLES  8'h10
`define REG_RESET_VALUE        16'h0000

`endif

// *** design/tick_divider.v ***
// Power-of-two tick divider for the general-purpose timer
`timescale 1ns/1ps
`include "timer_wdog_regs.vh"

module tick_divider (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        run,
    input  wire        restart,
    input  wire [3:0]  div_code,
    output reg         tick_ff
);

    reg  [12:0] cnt_ff;
    reg  [12:0] nxt_cnt;
    reg  [12:0] limit;
    reg  [3:0]  code;

    // Codes above the top code saturate to divide by 8192
    always @* begin
        code = (div_code > `DIV_CODE_MAX) ? `DIV_CODE_MAX : div_code;
        limit = 13'h0001;
        limit = (limit << code) << 1;
        limit = limit - 13'h0001;
    end

    // Divide by two to the code plus one
    always @* begin
        if (restart || !run || cnt_ff >= limit)
            nxt_cnt = 13'h0000;
        else
            nxt_cnt = cnt_ff + 13'h0001;
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_ff  <= 13'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= run && !restart && (cnt_ff >= limit);
        end
    end

endmodule

// *** design/timer_watchdog_prescale_ctrl.v ***
// Watchdog prescaler with key lock and 32-bit general-purpose down timer
// Summary of operation
// - Lock register reads state: 00 idle, 01 wait key two, 11 open.
// - Prescale start value is written only when the lock is open.
// - A 16-bit prescale start value reloads the prescale down counter.
// - Each prescale counter zero decrements the watchdog counter by one.
// - Prescale register reads return last written start value.
// - Control bit 15 enables both timer prescaler and counter.
// - Divide field bits 5:2; code 0 divides by 2, code 12 by 8192.
// - Auto-reload bit 1 reloads the counter at zero.
// - Writing start bit 1 loads and starts; writing 0 stops.
// - Period is 32 bits: low word and high word registers.
// - Counter is 32 bits; low word read and written through register.
// - Counter high word read and written through second register.
// - Timer expiry latches a flag, cleared by writing one.
// - Enabled watchdog counting to zero asserts chip reset.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "timer_wdog_regs.vh"

module timer_watchdog_prescale_ctrl (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata_ff,
    output reg         irq_ff,
    output reg         chip_reset_ff
);

    reg  [1:0]  lock_state_ff;
    reg  [1:0]  nxt_lock_state;
    reg  [15:0] ps_start_ff;
    reg  [15:0] ps_count_ff;
    reg  [15:0] wd_count_ff;
    reg         wd_enable_ff;
    reg         wd_running_ff;
    reg  [7:0]  rst_pulse_ff;
    reg  [15:0] control_ff;
    reg  [31:0] period_ff;
    reg  [31:0] count_ff;
    reg  [31:0] nxt_count;
    reg         running_ff;
    reg         nxt_running;
    reg         expire;
    reg  [`IRQ_WIDTH-1:0] status_ff;
    reg  [`IRQ_WIDTH-1:0] mask_ff;
    reg  [`IRQ_WIDTH-1:0] nxt_status;
    reg  [15:0] nxt_rdata;
    reg         wd_expire;

    wire        tick;
    wire        timer_en;
    wire        start_wr;
    wire        restart_div;

    // Single decode shared by every register write
    function wr_hit;
        input [3:0] addr;
        input [3:0] target;
        input       strobe;
        begin
            wr_hit = strobe && (addr == target);
        end
    endfunction

    assign timer_en = control_ff[`TCR_ENABLE_BIT];
    assign start_wr = wr_hit(reg_addr, `ADDR_TIMER_CONTROL, reg_wr)
                      && reg_wdata[`TCR_START_BIT];
    assign restart_div = start_wr;

    // Prescaler runs only while enabled and counting
    tick_divider u_tick_divider (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .run      (timer_en && running_ff),
        .restart  (restart_div),
        .div_code (control_ff[`TCR_DIV_MSB:`TCR_DIV_LSB]),
        .tick_ff  (tick)
    );

    // Lock state machine for the prescale key sequence
    always @* begin
        nxt_lock_state = lock_state_ff;
        if (wr_hit(reg_addr, `ADDR_WD_PRESCALE_LOCK, reg_wr)) begin
            case (lock_state_ff)
                `LOCK_IDLE: begin
                    if (reg_wdata == `PRESCALE_KEY1)
                        nxt_lock_state = `LOCK_WAIT_KEY2;
                end
                `LOCK_WAIT_KEY2: begin
                    // Second key must follow the first
                    if (reg_wdata == `PRESCALE_KEY2)
                        nxt_lock_state = `LOCK_OPEN;
                    else
                        nxt_lock_state = `LOCK_IDLE;
                end
                `LOCK_OPEN: begin
                    nxt_lock_state = (reg_wdata == `PRESCALE_KEY1) ?
                                     `LOCK_WAIT_KEY2 : `LOCK_IDLE;
                end
                default: begin
                    nxt_lock_state = `LOCK_IDLE;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            lock_state_ff <= `LOCK_IDLE;
            ps_start_ff   <= `REG_RESET_VALUE;
        end else begin
            lock_state_ff <= nxt_lock_state;
            // Start value accepted only when unlocked
            if (wr_hit(reg_addr, `ADDR_WD_PRESCALE_START, reg_wr)
                && lock_state_ff == `LOCK_OPEN)
                ps_start_ff <= reg_wdata;
        end
    end

    // Watchdog prescaler and main counter
    always @* begin
        wd_expire = wd_enable_ff && wd_running_ff && ps_count_ff == 16'h0000
                    && wd_count_ff == 16'h0001;
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            ps_count_ff   <= 16'h0000;
            wd_count_ff   <= 16'h0000;
            wd_enable_ff  <= 1'b0;
            wd_running_ff <= 1'b0;
            rst_pulse_ff  <= 8'h00;
            chip_reset_ff <= 1'b0;
        end else begin
            if (wr_hit(reg_addr, `ADDR_WD_CONTROL, reg_wr))
                wd_enable_ff <= reg_wdata[0];
            if (wr_hit(reg_addr, `ADDR_WD_COUNT, reg_wr)) begin
                wd_count_ff   <= reg_wdata;
                ps_count_ff   <= ps_start_ff;
                wd_running_ff <= reg_wdata != 16'h0000;
            end else if (wd_enable_ff && wd_running_ff) begin
                // Prescale counter reloads from start value
                if (ps_count_ff == 16'h0000) begin
                    ps_count_ff <= ps_start_ff;
                    wd_count_ff <= wd_count_ff - 16'h0001;
                    if (wd_count_ff == 16'h0001)
                        wd_running_ff <= 1'b0;
                end else begin
                    ps_count_ff <= ps_count_ff - 16'h0001;
                end
            end
            // Chip reset pulse at watchdog zero
            if (wd_expire)
                rst_pulse_ff <= `WD_RESET_PULSE_CYCLES;
            else if (rst_pulse_ff != 8'h00)
                rst_pulse_ff <= rst_pulse_ff - 8'h01;
            chip_reset_ff <= wd_expire || rst_pulse_ff > 8'h01;
        end
    end

    // Timer counter next value
    always @* begin
        nxt_count   = count_ff;
        nxt_running = running_ff;
        expire      = 1'b0;
        if (timer_en && running_ff && tick) begin
            if (count_ff == 32'h0000_0000 || count_ff == 32'h0000_0001) begin
                expire = 1'b1;
                if (control_ff[`TCR_RELOAD_BIT]) begin
                    nxt_count = period_ff;
                end else begin
                    nxt_count   = 32'h0000_0000;
                    nxt_running = 1'b0;
                end
            end else begin
                nxt_count = count_ff - 32'h0000_0001;
            end
        end
        if (wr_hit(reg_addr, `ADDR_TIMER_CONTROL, reg_wr)) begin
            // Start loads full period, zero stops
            if (reg_wdata[`TCR_START_BIT]) begin
                nxt_count   = period_ff;
                nxt_running = 1'b1;
                expire      = 1'b0;
            end else begin
                nxt_running = 1'b0;
                expire      = 1'b0;
            end
        end
        if (wr_hit(reg_addr, `ADDR_TIMER_COUNT_LOW, reg_wr))
            nxt_count = {count_ff[31:16], reg_wdata};
        if (wr_hit(reg_addr, `ADDR_TIMER_COUNT_HIGH, reg_wr))
            nxt_count = {reg_wdata, count_ff[15:0]};
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            control_ff <= `REG_RESET_VALUE;
            period_ff  <= 32'h0000_0000;
            count_ff   <= 32'h0000_0000;
            running_ff <= 1'b0;
        end else begin
            if (wr_hit(reg_addr, `ADDR_TIMER_CONTROL, reg_wr))
                control_ff <= reg_wdata & `TCR_WRITE_MASK;
            else if (!running_ff)
                control_ff[`TCR_START_BIT] <= 1'b0;
            // Period split into low and high words
            if (wr_hit(reg_addr, `ADDR_TIMER_PERIOD_LOW, reg_wr))
                period_ff[15:0] <= reg_wdata;
            if (wr_hit(reg_addr, `ADDR_TIMER_PERIOD_HIGH, reg_wr))
                period_ff[31:16] <= reg_wdata;
            count_ff   <= nxt_count;
            running_ff <= nxt_running;
        end
    end

    // Sticky flags, set wins over write-one clear
    always @* begin
        nxt_status = status_ff;
        if (wr_hit(reg_addr, `ADDR_IRQ_STATUS, reg_wr))
            nxt_status = status_ff & ~reg_wdata[`IRQ_WIDTH-1:0];
        if (expire)
            nxt_status[`IRQ_TIMER_BIT] = 1'b1;
        if (wd_expire)
            nxt_status[`IRQ_WDOG_BIT] = 1'b1;
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            status_ff <= {`IRQ_WIDTH{1'b0}};
            mask_ff   <= {`IRQ_WIDTH{1'b0}};
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            if (wr_hit(reg_addr, `ADDR_IRQ_MASK, reg_wr))
                mask_ff <= reg_wdata[`IRQ_WIDTH-1:0];
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    // Read mux
    always @* begin
        nxt_rdata = 16'h0000;
        case (reg_addr)
            `ADDR_WD_PRESCALE_LOCK:  nxt_rdata = {14'h0000, lock_state_ff};
            `ADDR_WD_PRESCALE_START: nxt_rdata = ps_start_ff;
            `ADDR_TIMER_CONTROL:     nxt_rdata = control_ff;
            `ADDR_TIMER_PERIOD_LOW:  nxt_rdata = period_ff[15:0];
            `ADDR_TIMER_PERIOD_HIGH: nxt_rdata = period_ff[31:16];
            `ADDR_TIMER_COUNT_LOW:   nxt_rdata = count_ff[15:0];
            `ADDR_TIMER_COUNT_HIGH:  nxt_rdata = count_ff[31:16];
            `ADDR_IRQ_STATUS:        nxt_rdata = {14'h0000, status_ff};
            `ADDR_IRQ_MASK:          nxt_rdata = {14'h0000, mask_ff};
            `ADDR_WD_CONTROL:        nxt_rdata = {15'h0000, wd_enable_ff};
            `ADDR_WD_COUNT:          nxt_rdata = wd_count_ff;
            default:                 nxt_rdata = 16'h0000;
        endcase
    end

    always @(posedge core_clk) begin
        if (!reset_n)
            reg_rdata_ff <= 16'h0000;
        else if (reg_rd)
            reg_rdata_ff <= nxt_rdata;
        else
            reg_rdata_ff <= 16'h0000;
    end

endmodule

// *** tb/twd_properties.sv ***
// Port assertions for the prescale lock and timer block
`timescale 1ns/1ps
module twd_chk (
    input wire        core_clk,
    input wire        reset_n,
    input wire [3:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata_ff,
    input wire        irq_ff,
    input wire        chip_reset_ff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    reg  [7:0] hi_ff;
    wire       wl = reg_wr && reg_addr == 4'h0;
    wire       rl = reg_rd && reg_addr == 4'h0;
    wire       nk = reg_wdata != 16'h5a5a && reg_wdata != 16'ha5a5;
    // Age of the current chip reset pulse
    always @(posedge core_clk) begin
        if (!reset_n || !chip_reset_ff)
            hi_ff <= 8'h00;
        else
            hi_ff <= hi_ff + 8'h01;
    end
    property p_lock_fmt;
        rl |=> reg_rdata_ff[15:2] == 14'h0 && reg_rdata_ff[1:0] != 2'h2;
    endproperty
    a_lock_fmt: assert property (p_lock_fmt) else $error("lock read");
    property p_lock_clr;
        wl && nk ##1 rl |=> reg_rdata_ff == 16'h0000;
    endproperty
    a_lock_clr: assert property (p_lock_clr) else $error("lock idle");
    property p_lock_open;
        wl && nk ##1 wl && reg_wdata == 16'h5a5a
        ##1 wl && reg_wdata == 16'ha5a5 ##1 rl |=> reg_rdata_ff == 16'h0003;
    endproperty
    a_lock_open: assert property (p_lock_open) else $error("unlock");
    property p_prd_rw;
        reg_wr && (reg_addr == 4'h3 || reg_addr == 4'h4)
        ##1 reg_rd && $stable(reg_addr) |=> reg_rdata_ff == $past(reg_wdata, 2);
    endproperty
    a_prd_rw: assert property (p_prd_rw) else $error("period");
    property p_stop;
        reg_wr && reg_addr == 4'h2 && !reg_wdata[0]
        ##1 reg_rd && reg_addr == 4'h2 |=> !reg_rdata_ff[0];
    endproperty
    a_stop: assert property (p_stop) else $error("stop");
    property p_mask_off;
        reg_wr && reg_addr == 4'h8 && reg_wdata[1:0] == 2'h0
        ##1 !(reg_wr && reg_addr == 4'h8) |=> !irq_ff;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("mask");
    property p_rst_hold;
        chip_reset_ff |-> hi_ff < 8'h10;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("rst long");
    property p_rst_len;
        $fell(chip_reset_ff) |-> hi_ff == 8'h10;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("rst short");
    c_open: cover property (rl ##1 reg_rdata_ff == 16'h0003);
    c_irq: cover property ($rose(irq_ff));
    c_rst: cover property ($rose(chip_reset_ff));
endmodule
bind timer_watchdog_prescale_ctrl twd_chk chk_u (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff),
    .irq_ff(irq_ff),
    .chip_reset_ff(chip_reset_ff)
);

// *** tb/timer_watchdog_prescale_ctrl_tb_top.sv ***
// Self-checking bench for the prescale lock and timer block
`timescale 1ns/1ps
module timer_watchdog_prescale_ctrl_tb_top;
    localparam [15:0] CODES = 16'hfc30;
    reg         core_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire [15:0] reg_rdata_ff;
    wire        irq_ff;
    wire        chip_reset_ff;
    reg         rd_d = 1'b0;
    reg  [31:0] exp_q[$];
    reg  [31:0] nt;
    reg  [15:0] v;
    reg  [3:0]  c;
    integer     n_mismatch = 0;
    integer     n_checks = 0;
    integer     i;
    integer     cyc;
    integer     d;
    always #5 core_clk = ~core_clk;
    timer_watchdog_prescale_ctrl dut_u (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff),
        .irq_ff(irq_ff),
        .chip_reset_ff(chip_reset_ff)
    );
    task chk(input string s, input [15:0] e, input [15:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input [3:0] a, input [15:0] x);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input [3:0] a, input [15:0] e, input [15:0] m);
        exp_q.push_back({m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task idle(input integer n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    // Settled cycles until irq (sel 0) or chip reset (sel 1) rises
    task wait_hi(input sel, input integer lim);
        idle(0);
        cyc = 0;
        while ((sel ? chip_reset_ff : irq_ff) !== 1'b1 && cyc < lim) begin
            @(posedge core_clk);
            #1;
            cyc = cyc + 1;
        end
        @(posedge core_clk);
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge core_clk) rd_d <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_d) begin
            nt = exp_q.pop_front();
            chk("rdata", nt[15:0] & nt[31:16], reg_rdata_ff & nt[31:16]);
        end
    end
    // Two slowest divide codes need about 33k cycles; allow half again
    initial begin
        #500000;
        n_mismatch = n_mismatch + 1;
        end_sim;
    end
    initial begin
        v = $urandom(99716);
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        for (i = 0; i < 11; i = i + 1)
            rd(i[3:0], 16'h0000, 16'hffff);
        rd(4'hf, 16'h0000, 16'hffff);
        wr(4'h0, 16'h1234);
        wr(4'h0, 16'h5a5a);
        wr(4'h0, 16'ha5a5);
        rd(4'h0, 16'h0003, 16'hffff);
        v = $urandom;
        wr(4'h1, v);
        rd(4'h1, v, 16'hffff);
        wr(4'h0, 16'h5a5a);
        rd(4'h0, 16'h0001, 16'hffff);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0000, 16'hffff);
        wr(4'h1, ~v);
        rd(4'h1, v, 16'hffff);
        for (i = 3; i < 7; i = i + 1) begin
            v = $urandom;
            wr(i[3:0], v);
            rd(i[3:0], v, 16'hffff);
        end
        wr(4'h2, 16'hffff);
        rd(4'h2, 16'h803f, 16'hffff);
        wr(4'h2, 16'h0000);
        rd(4'h2, 16'h0000, 16'hffff);
        v = $urandom;
        wr(4'h3, v);
        wr(4'h4, 16'h0001);
        wr(4'h2, 16'h8031);
        rd(4'h5, v, 16'hffff);
        rd(4'h6, 16'h0001, 16'hffff);
        wr(4'h3, 16'h0005);
        wr(4'h4, 16'h0000);
        wr(4'h7, 16'h0003);
        wr(4'h2, 16'h0001);
        idle(20);
        rd(4'h5, 16'h0005, 16'hffff);
        rd(4'h7, 16'h0000, 16'h0001);
        for (i = 0; i < 4; i = i + 1) begin
            c = CODES[4 * i +: 4];
            d = 2 << ((c > 4'hc) ? 12 : c);
            wr(4'h3, 16'h0002);
            wr(4'h7, 16'h0003);
            wr(4'h8, 16'h0001);
            wr(4'h2, {10'h200, c, 2'h1});
            wait_hi(1'b0, 2 * d + 40);
            chk("expiry", 16'h1, {15'h0, cyc >= 2*d-2 && cyc <= 2*d+4});
            rd(4'h5, 16'h0000, 16'hffff);
            rd(4'h2, {10'h200, c, 2'h0}, 16'hffff);
            rd(4'h7, 16'h0001, 16'h0003);
            wr(4'h8, 16'h0000);
            idle(2);
            #1 chk("irq", 16'h0000, {15'h0, irq_ff});
            @(posedge core_clk);
        end
        wr(4'h3, 16'h0006);
        wr(4'h8, 16'h0001);
        wr(4'h7, 16'h0003);
        wr(4'h2, 16'h8003);
        wait_hi(1'b0, 40);
        wr(4'h7, 16'h0001);
        idle(2);
        #1 chk("w1c", 16'h0000, {15'h0, irq_ff});
        @(posedge core_clk);
        wait_hi(1'b0, 40);
        chk("reload", 16'h0001, {15'h0, cyc > 4 && cyc < 14});
        rd(4'h2, 16'h8003, 16'hffff);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h5a5a);
        wr(4'h0, 16'ha5a5);
        wr(4'h1, 16'h0001);
        wr(4'ha, 16'h0003);
        idle(8);
        #1 chk("wd off", 16'h0000, {15'h0, chip_reset_ff});
        @(posedge core_clk);
        rd(4'ha, 16'h0003, 16'hffff);
        wr(4'h9, 16'h0001);
        wait_hi(1'b1, 60);
        chk("wdog", 16'h0001, {15'h0, cyc >= 4 && cyc <= 12});
        rd(4'ha, 16'h0000, 16'hffff);
        idle(20);
        end_sim;
    end
endmodule
